// file: testbench/engine_model.sv
// Purpose: drawing engine stand-in driving the live status inputs
// Assumes: one start pulse per drawing command
// Notes: the blocked flag drops before busy, as a real pipeline would
`timescale 1ns/1ps
`default_nettype none
module engine_model #(
    parameter int BUSY_CYCLES = 8,
    parameter int BLOCK_CYCLES = 3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // command side
    input wire logic start,
    input wire logic pick_in,
    // status levels and clip window
    output logic draw_issue_blocked,
    output logic engine_busy,
    output logic pick_detected,
    output logic [31:0] win_min,
    output logic [31:0] win_max
);
    int count;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 0;
        end else if (start) begin
            count <= BUSY_CYCLES;
        end else if (count > 0) begin
            count <= count - 1;
        end
    end
    // blocked only while early stages hold the last command
    assign draw_issue_blocked =
        count > BUSY_CYCLES - BLOCK_CYCLES;
    assign engine_busy = count > 0;
    assign pick_detected = pick_in;
    // window -100..100 on both axes, so the origin lies inside
    assign win_min = {16'hFF9C, 16'hFF9C};
    assign win_max = {16'h0064, 16'h0064};
endmodule : engine_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the vertex and status registers
// Assumes: host strobes driven on falling edges, reads answer one cycle on
// Notes: clip cases use collinear vertices so concavity stays clear
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vertex_regs_pkg::*;
    logic sys_clk, arst_n, wr_strobe, rd_strobe, cmd_read, load_strobe;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wr_data, load_x, load_y, rd_data, status_word;
    logic [31:0] win_min, win_max;
    logic rd_valid, start, pick_in, blocked, busy, pick;
    logic [1:0] vertex_index;
    logic [31:0] d;
    int n_errors = 0;
    int n_checks = 0;

    vertex_status_regs uut (.sys_clk(sys_clk), .arst_n(arst_n),
        .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wr_data(wr_data), .cmd_read(cmd_read), .rd_data(rd_data),
        .rd_valid(rd_valid), .load_strobe(load_strobe), .load_x(load_x),
        .load_y(load_y), .draw_issue_blocked(blocked), .engine_busy(busy),
        .pick_detected(pick), .win_min(win_min), .win_max(win_max),
        .status_word(status_word), .vertex_index(vertex_index));
    engine_model eng (.sys_clk(sys_clk), .arst_n(arst_n), .start(start),
        .pick_in(pick_in), .draw_issue_blocked(blocked),
        .engine_busy(busy), .pick_detected(pick), .win_min(win_min),
        .win_max(win_max));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [14:0] ca(input logic [1:0] s,
        input logic r, input logic [1:0] w);
        return {7'h30, s, r, w, 3'h0};
    endfunction : ca
    function automatic logic [14:0] ce(input logic [4:0] e);
        return {7'h21, 1'b1, e, 2'h0};
    endfunction : ce

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk
    task automatic wr(input logic [14:0] a, input logic [31:0] v);
        @(negedge sys_clk);
        addr = a;
        wr_data = v;
        wr_strobe = 1'b1;
        @(negedge sys_clk);
        wr_strobe = 1'b0;
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic c,
        output logic [31:0] v);
        int i;
        @(negedge sys_clk);
        addr = a;
        cmd_read = c;
        rd_strobe = 1'b1;
        @(negedge sys_clk);
        rd_strobe = 1'b0;
        cmd_read = 1'b0;
        v = 32'hDEAD_BEEF;
        // bounded wait; the answer is due on the next edge
        for (i = 0; i < 3; i++) begin
            if (rd_valid === 1'b1) begin
                v = rd_data;
                break;
            end
            @(negedge sys_clk);
        end
    endtask : rd
    task automatic rdc(input logic [14:0] a, input logic c,
        input logic [31:0] exp);
        rd(a, c, d);
        chk(d, exp);
    endtask : rdc
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        #200us;
        n_errors++;
        results();
    end

    initial begin
        arst_n = 1'b0;
        {wr_strobe, rd_strobe, cmd_read, load_strobe, start, pick_in} = '0;
        addr = '0;
        wr_data = '0;
        load_x = '0;
        load_y = '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        chk(status_word, 32'h0000_0002);
        chk({30'h0, vertex_index}, 32'h0000_0000);
        // every slot in both 32-bit forms, then packed read-back
        for (int s = 0; s < 4; s++) begin
            wr(ca(s, 1'b0, CW_X32), 32'h0000_0100 + s);
            wr(ca(s, 1'b0, CW_Y32), 32'h0000_0200 + s);
        end
        for (int s = 0; s < 4; s++) begin
            rdc(ca(s, 1'b0, CW_X32), 1'b0, 32'h0000_0100 + s);
            rdc(ca(s, 1'b0, CW_Y32), 1'b0, 32'h0000_0200 + s);
            rdc(ca(s, 1'b0, CW_PACKED), 1'b0,
                {16'h0100 + 16'(s), 16'h0200 + 16'(s)});
        end
        // unused width code moves nothing and reads zero
        wr(ca(0, 1'b0, CW_UNUSED), 32'hAAAA_5555);
        rdc(ca(0, 1'b0, CW_UNUSED), 1'b0, 32'h0000_0000);
        rdc(ca(0, 1'b0, CW_X32), 1'b0, 32'h0000_0100);
        rdc(15'h7F00, 1'b0, 32'h0000_0000);
        // packed halves are signed
        wr(ca(3, 1'b0, CW_PACKED), {16'hFFF0, 16'h0007});
        rdc(ca(3, 1'b0, CW_X32), 1'b0, 32'hFFFF_FFF0);
        rdc(ca(3, 1'b0, CW_Y32), 1'b0, 32'h0000_0007);
        // window-relative write adds the signed offset
        wr(ce(ENT_WOFF), {16'h0010, 16'hFFFE});
        rdc(ce(ENT_WOFF), 1'b0, {16'h0010, 16'hFFFE});
        wr(ca(1, 1'b1, CW_PACKED), {16'h0005, 16'h0005});
        rdc(ca(1, 1'b0, CW_X32), 1'b0, 32'h0000_0015);
        rdc(ca(1, 1'b0, CW_Y32), 1'b0, 32'h0000_0003);
        // 32-bit relative form takes the sign-extended x half
        wr(ca(2, 1'b1, CW_X32), 32'h0000_0020);
        rdc(ca(2, 1'b0, CW_X32), 1'b0, 32'h0000_0030);
        // index register and load computation, wrapping 3 to 0
        wr(ce(ENT_INDEX), 32'h0000_0002);
        rdc(ce(ENT_INDEX), 1'b0, 32'h0000_0002);
        chk({30'h0, vertex_index}, 32'h0000_0002);
        for (int k = 0; k < 2; k++) begin
            @(negedge sys_clk);
            load_x = 32'h0000_0007 + k;
            load_y = 32'h0000_0009 + k;
            load_strobe = 1'b1;
            @(negedge sys_clk);
            load_strobe = 1'b0;
        end
        rdc(ca(2, 1'b0, CW_PACKED), 1'b0, 32'h0007_0009);
        rdc(ca(3, 1'b0, CW_PACKED), 1'b0, 32'h0008_000A);
        chk({30'h0, vertex_index}, 32'h0000_0000);
        // clip classes: all beyond max x, then straddle, then out of range
        for (int s = 0; s < 4; s++) begin
            wr(ca(s, 1'b0, CW_PACKED), {16'h00C8, 16'h0000});
        end
        @(negedge sys_clk);
        chk(status_word, 32'h0000_0004);
        wr(ca(0, 1'b0, CW_X32), 32'h0000_0000);
        @(negedge sys_clk);
        chk(status_word, 32'h0000_0001);
        wr(ca(3, 1'b0, CW_X32), 32'h0001_0000);
        @(negedge sys_clk);
        chk(status_word, 32'h0000_0071);
        rdc(ce(ENT_RANGE), 1'b0, 32'h0000_0080);
        rdc(ce(ENT_XCLIP), 1'b0, 32'h0000_000E);
        rdc(ce(ENT_YCLIP), 1'b0, 32'h0000_0000);
        wr(15'h2000, 32'hFFFF_FFFF);
        rdc(15'h2000, 1'b0, 32'h0000_0071);
        // engine levels and pick appear live; command reads return status
        @(negedge sys_clk);
        start = 1'b1;
        pick_in = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        rdc(15'h0000, 1'b1, 32'hC000_00F1);
        chk(status_word, 32'hC000_00F1);
        for (int i = 0; i < 20; i++) begin
            rd(15'h2000, 1'b0, d);
            if (d[ST_BUSY] === 1'b0) begin
                break;
            end
        end
        chk(d, 32'h0000_00F1);
        pick_in = 1'b0;
        rdc(15'h0000, 1'b1, 32'h0000_0071);
        // mixed turn directions inside the window: concave and visible
        wr(ca(0, 1'b0, CW_PACKED), {16'h0000, 16'h0000});
        wr(ca(1, 1'b0, CW_PACKED), {16'h0028, 16'h0000});
        wr(ca(2, 1'b0, CW_PACKED), {16'h000A, 16'h000A});
        wr(ca(3, 1'b0, CW_PACKED), {16'h0000, 16'h0028});
        @(negedge sys_clk);
        chk(status_word, 32'h0000_001A);
        results();
    end
endmodule : testbench
`default_nettype wire

// file: verilog/vertex_check.sv
// Purpose: per-vertex clip, range and turn-direction checks
// Assumes: window limits are packed signed 16-bit x (high) and y (low)
// Notes: purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
module vertex_check
    import vertex_regs_pkg::*;
(
    // this vertex and its neighbours
    input wire logic [31:0] cur_x,
    input wire logic [31:0] cur_y,
    input wire logic [31:0] prev_x,
    input wire logic [31:0] prev_y,
    input wire logic [31:0] next_x,
    input wire logic [31:0] next_y,
    // clip window
    input wire logic [31:0] win_min,
    input wire logic [31:0] win_max,
    // results
    output logic x_lt,
    output logic x_gt,
    output logic y_lt,
    output logic y_gt,
    output logic x_range,
    output logic y_range,
    output logic turn_neg,
    output logic turn_pos
);
    logic signed [31:0] sx;
    logic signed [31:0] sy;
    logic signed [32:0] ax;
    logic signed [32:0] ay;
    logic signed [32:0] bx;
    logic signed [32:0] by;
    logic signed [66:0] prod_a;
    logic signed [66:0] prod_b;
    logic signed [66:0] cross_prod;

    assign sx = $signed(cur_x);
    assign sy = $signed(cur_y);
    assign x_lt = sx < $signed({{16{win_min[31]}}, win_min[31:16]});
    assign x_gt = sx > $signed({{16{win_max[31]}}, win_max[31:16]});
    assign y_lt = sy < $signed({{16{win_min[15]}}, win_min[15:0]});
    assign y_gt = sy > $signed({{16{win_max[15]}}, win_max[15:0]});
    assign x_range = (sx < RANGE_MIN) || (sx > RANGE_MAX);
    assign y_range = (sy < RANGE_MIN) || (sy > RANGE_MAX);
    // edge vectors into and out of this vertex
    assign ax = $signed({cur_x[31], cur_x}) - $signed({prev_x[31], prev_x});
    assign ay = $signed({cur_y[31], cur_y}) - $signed({prev_y[31], prev_y});
    assign bx = $signed({next_x[31], next_x}) - $signed({cur_x[31], cur_x});
    assign by = $signed({next_y[31], next_y}) - $signed({cur_y[31], cur_y});
    // operands widen before multiplying, so no product can wrap
    assign prod_a = ax * by;
    assign prod_b = ay * bx;
    assign cross_prod = prod_a - prod_b;
    assign turn_neg = cross_prod < 0;
    assign turn_pos = cross_prod > 0;
endmodule : vertex_check
`default_nettype wire

// file: verilog/vertex_regs_pkg.sv
// Purpose: constants for the vertex coordinate and draw status registers
// Assumes: byte address bits 14..0 of a host register transfer
// Notes: coordinate width and reset figures shared by both design files
//
// Summary of operation
// - four vertex slots of x and y, slot picked by address bits 7..6
// - address bits 4..3 pick x 32-bit, y 32-bit or packed; 00 unused
// - packed form carries x in upper 16 bits, y in lower 16 bits
// - drawing status word is read-only: engine busy and clip outcome
// - status word recomputed whenever any coordinate register changes
// - reads of quad, blit or byte pixel commands return the status word
// - window offset only translates relative coordinates, never clips
// - vertex index register selects slot written by load computation
// - each coordinate flagged when outside the engine's usable range
// - relative bit adds packed signed 16-bit window offset to writes
// - vertex index is a 2-bit unsigned value, host read and write
package vertex_regs_pkg;
    localparam int ADDR_W = 15;
    localparam int NUM_VERTS = 4;
    // address decode fields
    localparam logic [6:0] COORD_SPACE = 7'h30;
    localparam logic [6:0] CTRL_SPACE = 7'h21;
    localparam logic [12:0] STATUS_WORD_ADDR = 13'h0800;
    localparam int SPACE_HI = 14;
    localparam int SPACE_LO = 8;
    localparam int SLOT_HI = 7;
    localparam int SLOT_LO = 6;
    localparam int RELATIVE_BIT = 5;
    localparam int WIDTH_HI = 4;
    localparam int WIDTH_LO = 3;
    localparam int ENTRY_HI = 6;
    localparam int ENTRY_LO = 2;
    // coord_width_select codes
    localparam logic [1:0] CW_UNUSED = 2'h0;
    localparam logic [1:0] CW_X32 = 2'h1;
    localparam logic [1:0] CW_Y32 = 2'h2;
    localparam logic [1:0] CW_PACKED = 2'h3;
    // control and condition entries
    localparam logic [4:0] ENT_RANGE = 5'h01;
    localparam logic [4:0] ENT_INDEX = 5'h03;
    localparam logic [4:0] ENT_WOFF = 5'h04;
    localparam logic [4:0] ENT_YCLIP = 5'h08;
    localparam logic [4:0] ENT_XCLIP = 5'h09;
    // status word bit positions
    localparam int ST_ISSUE = 31;
    localparam int ST_BUSY = 30;
    localparam int ST_PICK = 7;
    localparam int ST_PIX_SW = 6;
    localparam int ST_BLIT_SW = 5;
    localparam int ST_QUAD_SW = 4;
    localparam int ST_CONCAVE = 3;
    localparam int ST_HIDDEN = 2;
    localparam int ST_VISIBLE = 1;
    localparam int ST_STRADDLE = 0;
    // usable engine range is signed 16-bit
    localparam logic signed [31:0] RANGE_MIN = 32'shFFFF_8000;
    localparam logic signed [31:0] RANGE_MAX = 32'sh0000_7FFF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] INDEX_RESET = 2'h0;
    localparam logic [1:0] INDEX_STEP = 2'h1;

    typedef struct packed {
        logic [NUM_VERTS-1:0][31:0] x;
        logic [NUM_VERTS-1:0][31:0] y;
        logic [1:0] cindex;
        logic [31:0] woff;
        logic [7:0] range_flags;
        logic [7:0] xclip;
        logic [7:0] yclip;
        logic [4:0] quad_class;
        logic [31:0] rd_data;
        logic rd_valid;
    } regs_state_t;
endpackage : vertex_regs_pkg

// file: verilog/vertex_status_regs.sv
// Purpose: vertex coordinate registers and drawing status word
// Assumes: host transfers are one-cycle strobes decoded on address 14..0
// Notes: reads answer one cycle after the strobe; status lags writes one
`timescale 1ns/1ps
`default_nettype none
module vertex_status_regs
    import vertex_regs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // host register transfers
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [31:0] wr_data,
    input wire logic cmd_read,
    output logic [31:0] rd_data,
    output logic rd_valid,
    // load coordinate computation
    input wire logic load_strobe,
    input wire logic [31:0] load_x,
    input wire logic [31:0] load_y,
    // drawing engine side
    input wire logic draw_issue_blocked,
    input wire logic engine_busy,
    input wire logic pick_detected,
    input wire logic [31:0] win_min,
    input wire logic [31:0] win_max,
    output logic [31:0] status_word,
    output logic [1:0] vertex_index
);
    regs_state_t cur;
    regs_state_t next_s;

    logic coord_hit;
    logic ctrl_hit;
    logic status_hit;
    logic [1:0] slot;
    logic [1:0] cw;
    logic [4:0] entry;
    logic [31:0] off_x;
    logic [31:0] off_y;
    logic [31:0] wx;
    logic [31:0] wy;
    logic [31:0] px;
    logic [31:0] py;
    logic [NUM_VERTS-1:0] v_xlt;
    logic [NUM_VERTS-1:0] v_xgt;
    logic [NUM_VERTS-1:0] v_ylt;
    logic [NUM_VERTS-1:0] v_ygt;
    logic [NUM_VERTS-1:0] v_xr;
    logic [NUM_VERTS-1:0] v_yr;
    logic [NUM_VERTS-1:0] v_neg;
    logic [NUM_VERTS-1:0] v_pos;
    logic hidden;
    logic visible;
    logic concave;

    assign coord_hit = addr[SPACE_HI:SPACE_LO] == COORD_SPACE;
    assign ctrl_hit = addr[SPACE_HI:SPACE_LO] == CTRL_SPACE;
    assign status_hit = addr[SPACE_HI:ENTRY_LO] == STATUS_WORD_ADDR;
    assign slot = addr[SLOT_HI:SLOT_LO];
    assign cw = addr[WIDTH_HI:WIDTH_LO];
    assign entry = addr[ENTRY_HI:ENTRY_LO];

    // offset is a pure translation; clip limits never see it
    assign off_x = addr[RELATIVE_BIT] ? {{16{cur.woff[31]}}, cur.woff[31:16]}
                                 : ZERO_WORD;
    assign off_y = addr[RELATIVE_BIT] ? {{16{cur.woff[15]}}, cur.woff[15:0]}
                                 : ZERO_WORD;
    assign wx = wr_data + off_x;
    assign wy = wr_data + off_y;
    assign px = {{16{wr_data[31]}}, wr_data[31:16]} + off_x;
    assign py = {{16{wr_data[15]}}, wr_data[15:0]} + off_y;

    genvar gv;
    generate
        for (gv = 0; gv < NUM_VERTS; gv++) begin : g_vert
            vertex_check u_chk (
                .cur_x(cur.x[gv]),
                .cur_y(cur.y[gv]),
                .prev_x(cur.x[(gv + NUM_VERTS - 1) % NUM_VERTS]),
                .prev_y(cur.y[(gv + NUM_VERTS - 1) % NUM_VERTS]),
                .next_x(cur.x[(gv + 1) % NUM_VERTS]),
                .next_y(cur.y[(gv + 1) % NUM_VERTS]),
                .win_min(win_min),
                .win_max(win_max),
                .x_lt(v_xlt[gv]),
                .x_gt(v_xgt[gv]),
                .y_lt(v_ylt[gv]),
                .y_gt(v_ygt[gv]),
                .x_range(v_xr[gv]),
                .y_range(v_yr[gv]),
                .turn_neg(v_neg[gv]),
                .turn_pos(v_pos[gv])
            );
        end
    endgenerate

    // mixed turn directions mean a concave outline
    assign concave = (|v_neg) && (|v_pos);
    assign hidden = (&v_xlt) || (&v_xgt) || (&v_ylt) || (&v_ygt);
    assign visible = ~|{v_xlt, v_xgt, v_ylt, v_ygt};

    // live engine bits, registered clip and range bits
    always_comb begin
        status_word = ZERO_WORD;
        status_word[ST_ISSUE] = draw_issue_blocked;
        status_word[ST_BUSY] = engine_busy;
        status_word[ST_PICK] = pick_detected;
        status_word[ST_PIX_SW] = cur.range_flags[7] | cur.range_flags[3];
        status_word[ST_BLIT_SW] = |cur.range_flags;
        status_word[ST_QUAD_SW:ST_STRADDLE] = cur.quad_class;
    end

    always_comb begin
        next_s = cur;
        next_s.rd_valid = rd_strobe;
        // classification tracks the registers every cycle
        next_s.range_flags = {v_xr, v_yr};
        next_s.xclip = {v_xlt, v_xgt};
        next_s.yclip = {v_ylt, v_ygt};
        next_s.quad_class = {(|{v_xr, v_yr}) | concave, concave, hidden,
                             visible, ~hidden & ~visible};
        if (load_strobe) begin
            next_s.x[cur.cindex] = load_x;
            next_s.y[cur.cindex] = load_y;
            next_s.cindex = cur.cindex + INDEX_STEP;
        end
        if (wr_strobe && coord_hit) begin
            // code 00 writes nothing
            if (cw == CW_X32) begin
                next_s.x[slot] = wx;
            end else if (cw == CW_Y32) begin
                next_s.y[slot] = wy;
            end else if (cw == CW_PACKED) begin
                next_s.x[slot] = px;
                next_s.y[slot] = py;
            end
        end else if (wr_strobe && ctrl_hit) begin
            if (entry == ENT_INDEX) begin
                next_s.cindex = wr_data[1:0];
            end else if (entry == ENT_WOFF) begin
                next_s.woff = wr_data;
            end
        end
        if (rd_strobe) begin
            next_s.rd_data = ZERO_WORD;
            if (cmd_read || status_hit) begin
                next_s.rd_data = status_word;
            end else if (coord_hit) begin
                if (cw == CW_X32) begin
                    next_s.rd_data = cur.x[slot];
                end else if (cw == CW_Y32) begin
                    next_s.rd_data = cur.y[slot];
                end else if (cw == CW_PACKED) begin
                    next_s.rd_data = {cur.x[slot][15:0], cur.y[slot][15:0]};
                end
            end else if (ctrl_hit) begin
                if (entry == ENT_RANGE) begin
                    next_s.rd_data = {24'h00_0000, cur.range_flags};
                end else if (entry == ENT_INDEX) begin
                    next_s.rd_data = {30'h0000_0000, cur.cindex};
                end else if (entry == ENT_WOFF) begin
                    next_s.rd_data = cur.woff;
                end else if (entry == ENT_YCLIP) begin
                    next_s.rd_data = {24'h00_0000, cur.yclip};
                end else if (entry == ENT_XCLIP) begin
                    next_s.rd_data = {24'h00_0000, cur.xclip};
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
            // zeroed vertices sit inside a window that holds the origin
            cur.quad_class[ST_VISIBLE] <= 1'b1;
        end else begin
            cur <= next_s;
        end
    end

    assign rd_data = cur.rd_data;
    assign rd_valid = cur.rd_valid;
    assign vertex_index = cur.cindex;

    // checks
    a_packed_write_split: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wr_strobe && coord_hit && cw == CW_PACKED && !addr[RELATIVE_BIT]
        && !load_strobe |=> cur.x[$past(slot)][15:0] == $past(wr_data[31:16])
        && cur.y[$past(slot)][15:0] == $past(wr_data[15:0]))
        else $error("packed write did not split into x high, y low");
    a_offset_add: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wr_strobe && coord_hit && cw == CW_X32 && addr[RELATIVE_BIT]
        && !load_strobe |=> cur.x[$past(slot)] == $past(wr_data)
        + {{16{$past(cur.woff[31])}}, $past(cur.woff[31:16])})
        else $error("relative x write missed window offset");
    a_unused_width_nop: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wr_strobe && coord_hit && cw == CW_UNUSED && !load_strobe
        |=> cur.x == $past(cur.x) && cur.y == $past(cur.y))
        else $error("unused width code changed a coordinate");
    a_status_on_cmd: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        rd_strobe && cmd_read |=> rd_valid
        && rd_data[ST_BUSY] == $past(engine_busy)
        && rd_data[ST_ISSUE] == $past(draw_issue_blocked))
        else $error("command read did not return status word");
    a_pick_mirror: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        status_word[ST_PICK] == pick_detected)
        else $error("pick bit does not follow pick condition");
    a_class_follows: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wr_strobe && coord_hit && cw == CW_PACKED ##1 !wr_strobe
        && !load_strobe ##1 1'b1 |-> status_word[ST_HIDDEN] == $past(hidden)
        && status_word[ST_VISIBLE] == $past(visible))
        else $error("clip class stale after coordinate change");
    a_load_index_step: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        load_strobe && !(wr_strobe && ctrl_hit && entry == ENT_INDEX)
        && !(wr_strobe && coord_hit)
        |=> vertex_index == 2'($past(vertex_index) + INDEX_STEP)
        && cur.x[$past(vertex_index)] == $past(load_x))
        else $error("load computation missed the indexed slot");
    a_index_readback: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        wr_strobe && ctrl_hit && entry == ENT_INDEX ##1 rd_strobe
        && ctrl_hit && entry == ENT_INDEX && !load_strobe
        |=> rd_data == {30'h0000_0000, $past(wr_data[1:0], 2)})
        else $error("vertex index did not read back");
    a_range_flag: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        cur.range_flags[7] == $past(v_xr[3]))
        else $error("range flag does not track vertex 3 x");
    a_visible_excl: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        $onehot(status_word[ST_HIDDEN:ST_STRADDLE])
        || status_word[ST_HIDDEN:ST_STRADDLE] == 3'h6)
        else $error("quad class bits inconsistent");
    c_packed_write: cover property (@(posedge sys_clk)
        wr_strobe && coord_hit && cw == CW_PACKED && addr[RELATIVE_BIT]);
    c_cmd_status: cover property (@(posedge sys_clk)
        rd_strobe && cmd_read && engine_busy);
    c_concave: cover property (@(posedge sys_clk)
        status_word[ST_CONCAVE]);
    c_load_wrap: cover property (@(posedge sys_clk)
        load_strobe && vertex_index == 2'h3);
endmodule : vertex_status_regs
`default_nettype wire
